// ===== src/pinmux_top.sv
// Top: AHB-Lite register file, function mux and input qualification for six pins
// Overview of operation
// - Pin 16 field bits 1-0, GPIO/MOSI/CANtx/TZ5
// - Pin 17 field bits 3-2, GPIO/MISO/CANrx/TZ6
// - Pin 18 field bits 5-4, GPIO/SCLK/UARTtx/TZ1
// - Pin 32 bits 1-0, GPIO/SDA/syncin/SOCA
// - Pin 33 bits 3-2, GPIO/SCL/syncout/SOCB
// - Pin 34 only GPIO; upper bits 5-4 are written and read back, other codes leave it undriven
// - Function fields reset to GPIO
// - Port B high mux register all reserved
// - Port A four 8-bit period fields
// - Zero one clock, n gives 2n
// - Period applies to 3/6 sample windows
// - Sample count comes from select registers
// - Port B period bits 7-0 only
// - Writes below the enable register need protected write enable set
// - Select codes: sync, three, six, async
module pinmux_top
   import pinmux_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic SRST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // Pads: index 0..5 = pins 16,17,18,32,33,34
   input wire logic [NPINS-1:0] PAD_IN,
   output logic [NPINS-1:0] PAD_OUT,
   output logic [NPINS-1:0] PAD_OE,
   // General-purpose side
   input wire logic [NPINS-1:0] GPIO_OUT,
   input wire logic [NPINS-1:0] GPIO_DIR,
   output logic [NPINS-1:0] GPIO_IN,
   // SPI-A
   input wire logic SPI_A_MOSI_OUT,
   input wire logic SPI_A_MOSI_OE,
   output logic SPI_A_MOSI_IN,
   input wire logic SPI_A_MISO_OUT,
   input wire logic SPI_A_MISO_OE,
   output logic SPI_A_MISO_IN,
   input wire logic SPI_A_SCLK_OUT,
   input wire logic SPI_A_SCLK_OE,
   output logic SPI_A_SCLK_IN,
   // CAN-B, UART-B
   input wire logic CAN_B_TRANSMIT,
   output logic CAN_B_RECEIVE,
   input wire logic UART_B_TRANSMIT,
   // Trip zones
   output logic TRIP_ZONE_IN_1,
   output logic TRIP_ZONE_IN_5,
   output logic TRIP_ZONE_IN_6,
   // I2C-A, open drain: drives low only
   input wire logic I2C_A_SDA_OE,
   output logic I2C_A_SDA_IN,
   input wire logic I2C_A_SCL_OE,
   output logic I2C_A_SCL_IN,
   // PWM sync and ADC triggers
   output logic PWM_SYNC_INPUT,
   input wire logic PWM_SYNC_OUTPUT,
   input wire logic ADC_CONVERSION_START_A_OUT,
   input wire logic ADC_CONVERSION_START_B_OUT
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed
   {
      logic [31:0] rdata;
      logic [7:0] addr;
      logic wr_pend;
      logic prot_en;
      logic [5:0] fsel_a;
      logic [5:0] fsel_b;
      logic [31:0] period_a;
      logic [7:0] period_b;
      logic [5:0] qsel_a;
      logic [5:0] qsel_b;
      logic [NPINS-1:0] pad_out;
      logic [NPINS-1:0] pad_oe;
      logic [NPINS-1:0] gpio_in;
      logic spi_mosi_in;
      logic spi_miso_in;
      logic spi_sclk_in;
      logic can_rx;
      logic tz1;
      logic tz5;
      logic tz6;
      logic sda_in;
      logic scl_in;
      logic sync_in;
   } top_s;
   top_s st_r;
   top_s st_nxt;

   logic tick_a;
   logic tick_b;
   logic [NPINS-1:0] q_val;
   logic [1:0] fsel [NPINS];
   logic [1:0] qsel [NPINS];
   logic [NPINS-1:0] alt_out;
   logic [NPINS-1:0] alt_oe;
   logic addr_phase;
   logic prot_wr;

   // ****************************************
   // Qualification sampling
   // ****************************************
   // Pins 16-18 share the period field at bits 23-16
   sample_tick u_tick_a
   (
      .clk(CLK),
      .srst(SRST),
      .period(st_r.period_a[23:16]),
      .tick(tick_a)
   );

   sample_tick u_tick_b
   (
      .clk(CLK),
      .srst(SRST),
      .period(st_r.period_b),
      .tick(tick_b)
   );

   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         fsel[i] = st_r.fsel_a[2*i +: 2];
         fsel[i+3] = st_r.fsel_b[2*i +: 2];
         qsel[i] = st_r.qsel_a[2*i +: 2];
         qsel[i+3] = st_r.qsel_b[2*i +: 2];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NPINS; g++)
      begin : g_qual
         input_qual u_qual
         (
            .clk(CLK),
            .srst(SRST),
            .tick((g < 3) ? tick_a : tick_b),
            .qsel(qsel[g]),
            .is_gpio(fsel[g] == FSEL_GPIO),
            .pad_in(PAD_IN[g]),
            .value(q_val[g])
         );
      end
   endgenerate

   // ****************************************
   // Output routing
   // ****************************************
   always_comb
   begin
      alt_out = '0;
      alt_oe = '0;
      unique case (fsel[0])
         FSEL_ALT1:
         begin
            alt_out[0] = SPI_A_MOSI_OUT;
            alt_oe[0] = SPI_A_MOSI_OE;
         end
         FSEL_ALT2:
         begin
            alt_out[0] = CAN_B_TRANSMIT;
            alt_oe[0] = 1'b1;
         end
         default: alt_oe[0] = 1'b0;
      endcase
      if (fsel[1] == FSEL_ALT1)
      begin
         alt_out[1] = SPI_A_MISO_OUT;
         alt_oe[1] = SPI_A_MISO_OE;
      end
      unique case (fsel[2])
         FSEL_ALT1:
         begin
            alt_out[2] = SPI_A_SCLK_OUT;
            alt_oe[2] = SPI_A_SCLK_OE;
         end
         FSEL_ALT2:
         begin
            alt_out[2] = UART_B_TRANSMIT;
            alt_oe[2] = 1'b1;
         end
         default: alt_oe[2] = 1'b0;
      endcase
      unique case (fsel[3])
         FSEL_ALT1: alt_oe[3] = I2C_A_SDA_OE;
         FSEL_ALT3:
         begin
            alt_out[3] = ADC_CONVERSION_START_A_OUT;
            alt_oe[3] = 1'b1;
         end
         default: alt_oe[3] = 1'b0;
      endcase
      unique case (fsel[4])
         FSEL_ALT1: alt_oe[4] = I2C_A_SCL_OE;
         FSEL_ALT2:
         begin
            alt_out[4] = PWM_SYNC_OUTPUT;
            alt_oe[4] = 1'b1;
         end
         FSEL_ALT3:
         begin
            alt_out[4] = ADC_CONVERSION_START_B_OUT;
            alt_oe[4] = 1'b1;
         end
         default: alt_oe[4] = 1'b0;
      endcase
      // Pin 34 has no peripheral; reserved codes leave it undriven
   end

   // ****************************************
   // Bus and registers
   // ****************************************
   assign addr_phase = HSEL && HREADY && HTRANS[1];
   // Protected registers: every offset below the enable register
   assign prot_wr = st_r.wr_pend && (st_r.addr < OFS_PROTECT);

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.wr_pend = 1'b0;
      if (st_r.wr_pend)
      begin
         if (st_r.addr == OFS_PROTECT)
            st_nxt.prot_en = HWDATA[0];
         // Writes are dropped silently unless the enable is set
         if (prot_wr && st_r.prot_en)
         begin
            unique case (st_r.addr)
               OFS_A_FSEL_HIGH: st_nxt.fsel_a = HWDATA[5:0];
               OFS_B_FSEL_LOW: st_nxt.fsel_b = HWDATA[5:0] & FSEL_USED_MASK;
               OFS_A_PERIOD: st_nxt.period_a = HWDATA;
               OFS_B_PERIOD: st_nxt.period_b = HWDATA[7:0] & PERIOD_B_MASK;
               OFS_A_QSEL_HIGH: st_nxt.qsel_a = HWDATA[5:0];
               OFS_B_QSEL: st_nxt.qsel_b = HWDATA[5:0];
               default: st_nxt.wr_pend = 1'b0;
            endcase
         end
      end
      if (addr_phase)
      begin
         st_nxt.addr = HADDR[7:0];
         st_nxt.wr_pend = HWRITE;
         st_nxt.rdata = RESET_WORD;
         if (!HWRITE)
         begin
            // Reads the updated copy, so a write in its data phase is not missed by the next read
            unique case (HADDR[7:0])
               OFS_A_FSEL_HIGH: st_nxt.rdata = {26'h0, st_nxt.fsel_a};
               OFS_B_FSEL_LOW: st_nxt.rdata = {26'h0, st_nxt.fsel_b};
               OFS_A_PERIOD: st_nxt.rdata = st_nxt.period_a;
               OFS_B_PERIOD: st_nxt.rdata = {24'h0, st_nxt.period_b};
               OFS_A_QSEL_HIGH: st_nxt.rdata = {26'h0, st_nxt.qsel_a};
               OFS_B_QSEL: st_nxt.rdata = {26'h0, st_nxt.qsel_b};
               OFS_PROTECT: st_nxt.rdata = {31'h0, st_nxt.prot_en};
               OFS_PIN_STATE: st_nxt.rdata = {26'h0, q_val};
               default: st_nxt.rdata = RESET_WORD;
            endcase
         end
      end
      // Pad drive and peripheral inputs
      for (int i = 0; i < NPINS; i++)
      begin
         if (fsel[i] == FSEL_GPIO)
         begin
            st_nxt.pad_out[i] = GPIO_OUT[i];
            st_nxt.pad_oe[i] = GPIO_DIR[i];
         end
         else
         begin
            st_nxt.pad_out[i] = alt_out[i];
            st_nxt.pad_oe[i] = alt_oe[i];
         end
      end
      st_nxt.gpio_in = q_val;
      // Unselected peripherals see their idle level
      st_nxt.spi_mosi_in = (fsel[0] == FSEL_ALT1) ? q_val[0] : 1'b0;
      st_nxt.tz5 = (fsel[0] == FSEL_ALT3) ? q_val[0] : 1'b1;
      st_nxt.spi_miso_in = (fsel[1] == FSEL_ALT1) ? q_val[1] : 1'b0;
      st_nxt.can_rx = (fsel[1] == FSEL_ALT2) ? q_val[1] : 1'b1;
      st_nxt.tz6 = (fsel[1] == FSEL_ALT3) ? q_val[1] : 1'b1;
      st_nxt.spi_sclk_in = (fsel[2] == FSEL_ALT1) ? q_val[2] : 1'b0;
      st_nxt.tz1 = (fsel[2] == FSEL_ALT3) ? q_val[2] : 1'b1;
      st_nxt.sda_in = (fsel[3] == FSEL_ALT1) ? q_val[3] : 1'b1;
      st_nxt.sync_in = (fsel[3] == FSEL_ALT2) ? q_val[3] : 1'b0;
      st_nxt.scl_in = (fsel[4] == FSEL_ALT1) ? q_val[4] : 1'b1;
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         st_r <= '0;
         st_r.tz1 <= 1'b1;
         st_r.tz5 <= 1'b1;
         st_r.tz6 <= 1'b1;
         st_r.can_rx <= 1'b1;
         st_r.sda_in <= 1'b1;
         st_r.scl_in <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign HRDATA = st_r.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign PAD_OUT = st_r.pad_out;
   assign PAD_OE = st_r.pad_oe;
   assign GPIO_IN = st_r.gpio_in;
   assign SPI_A_MOSI_IN = st_r.spi_mosi_in;
   assign SPI_A_MISO_IN = st_r.spi_miso_in;
   assign SPI_A_SCLK_IN = st_r.spi_sclk_in;
   assign CAN_B_RECEIVE = st_r.can_rx;
   assign TRIP_ZONE_IN_1 = st_r.tz1;
   assign TRIP_ZONE_IN_5 = st_r.tz5;
   assign TRIP_ZONE_IN_6 = st_r.tz6;
   assign I2C_A_SDA_IN = st_r.sda_in;
   assign I2C_A_SCL_IN = st_r.scl_in;
   assign PWM_SYNC_INPUT = st_r.sync_in;
endmodule : pinmux_top

// ===== src/pinmux_pkg.sv
// Package: register map, field layout, codes and timing constants of the pin mux block
package pinmux_pkg;
   // ****************************************
   // Register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_A_FSEL_HIGH = 8'h00;
   localparam logic [7:0] OFS_B_FSEL_LOW = 8'h04;
   localparam logic [7:0] OFS_B_FSEL_HIGH = 8'h08;
   localparam logic [7:0] OFS_A_PERIOD = 8'h0c;
   localparam logic [7:0] OFS_B_PERIOD = 8'h10;
   localparam logic [7:0] OFS_A_QSEL_HIGH = 8'h14;
   localparam logic [7:0] OFS_B_QSEL = 8'h18;
   localparam logic [7:0] OFS_PROTECT = 8'h1c;
   localparam logic [7:0] OFS_PIN_STATE = 8'h20;
   // ****************************************
   // Field layout and reset values
   // ****************************************
   localparam int FSEL_W = 2;
   localparam int PERIOD_W = 8;
   localparam int NPINS = 6;
   localparam logic [5:0] FSEL_USED_MASK = 6'h3f;
   localparam logic [7:0] PERIOD_B_MASK = 8'hff;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0] FSEL_GPIO = 2'h0;
   localparam logic [1:0] FSEL_ALT1 = 2'h1;
   localparam logic [1:0] FSEL_ALT2 = 2'h2;
   localparam logic [1:0] FSEL_ALT3 = 2'h3;
   localparam logic [1:0] QSEL_SYNC = 2'h0;
   localparam logic [1:0] QSEL_THREE = 2'h1;
   localparam logic [1:0] QSEL_SIX = 2'h2;
   localparam logic [1:0] QSEL_ASYNC = 2'h3;
   localparam int SAMPLES_THREE = 3;
   localparam int SAMPLES_SIX = 6;
   localparam int PRESCALE_W = 9;
   // ****************************************
   // Timing: one system clock period per period unit
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int SYS_PERIOD_NS = 10;
   localparam int UNIT_CYCLES = (SYS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : pinmux_pkg

// ===== src/sample_tick.sv
// Sample strobe divider: one pulse per programmed qualification period
module sample_tick
   import pinmux_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Period field
   input wire logic [PERIOD_W-1:0] period,
   // Strobe out
   output logic tick
);
   typedef struct packed
   {
      logic [PRESCALE_W-1:0] cnt;
      logic tick;
   } tick_s;
   tick_s st_r;
   tick_s st_nxt;
   logic [PRESCALE_W-1:0] limit;

   always_comb
   begin
      // Zero means every clock; n means 2n clocks
      limit = (period == '0) ? PRESCALE_W'(UNIT_CYCLES - 1) : PRESCALE_W'({period, 1'b0} - 1'b1);
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt >= limit)
      begin
         st_nxt.cnt = '0;
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick = st_r.tick;
endmodule : sample_tick

// ===== src/input_qual.sv
// Per-pin input synchroniser and 3 or 6 sample qualifier
module input_qual
   import pinmux_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Controls
   input wire logic tick,
   input wire logic [1:0] qsel,
   input wire logic is_gpio,
   // Pin level
   input wire logic pad_in,
   // Result
   output logic value
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic [SAMPLES_SIX-1:0] hist;
      logic qual;
   } qual_s;
   qual_s st_r;
   qual_s st_nxt;
   logic [SAMPLES_SIX-1:0] win;
   logic all_hi;
   logic all_lo;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = pad_in;
      st_nxt.s2 = st_r.s1;
      win = '1;
      if (qsel == QSEL_THREE)
         win = {{(SAMPLES_SIX-SAMPLES_THREE){1'b0}}, {SAMPLES_THREE{1'b1}}};
      all_hi = ((st_r.hist & win) == win);
      all_lo = ((st_r.hist & win) == '0);
      if (tick)
         st_nxt.hist = {st_r.hist[SAMPLES_SIX-2:0], st_r.s2};
      // Change only when the whole window agrees
      if (all_hi)
         st_nxt.qual = 1'b1;
      else if (all_lo)
         st_nxt.qual = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   always_comb
   begin
      unique case (qsel)
         QSEL_THREE, QSEL_SIX: value = st_r.qual;
         QSEL_ASYNC: value = is_gpio ? st_r.s2 : pad_in;
         default: value = st_r.s2;
      endcase
   end
endmodule : input_qual

// ===== sim/pinmux_top_monitor.sv
// Checker: bus, reset and pin relations seen at the pin mux top ports
module pinmux_checker
   import pinmux_pkg::*;
(
   // Clock, reset and bus
   input wire logic CLK,
   input wire logic SRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   // Pins and peripheral inputs
   input wire logic [NPINS-1:0] PAD_IN,
   input wire logic [NPINS-1:0] PAD_OE,
   input wire logic [NPINS-1:0] GPIO_DIR,
   input wire logic [NPINS-1:0] GPIO_IN,
   input wire logic CAN_B_RECEIVE,
   input wire logic TRIP_ZONE_IN_5,
   input wire logic PWM_SYNC_INPUT
);
   logic rp, wp, prot;
   logic [7:0] ad;
   logic [5:0] fa;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);
   // ****************************************
   // Bus shadow: mux field follows only protected-enabled writes
   // ****************************************
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         rp <= 1'b0;
         wp <= 1'b0;
         prot <= 1'b0;
         fa <= 6'h00;
         ad <= 8'h00;
      end
      else if (HREADY)
      begin
         rp <= HSEL && HTRANS[1] && !HWRITE;
         wp <= HSEL && HTRANS[1] && HWRITE;
         ad <= HADDR[7:0];
         if (wp && ad == OFS_PROTECT)
            prot <= HWDATA[0];
         if (wp && prot && ad == OFS_A_FSEL_HIGH)
            fa <= HWDATA[5:0];
      end
   end
   a_reset_pads: assert property ($fell(SRST) |-> PAD_OE == 6'h00)
      else $error("pad enabled right after reset");
   a_reset_idle: assert property ($fell(SRST) |-> CAN_B_RECEIVE && TRIP_ZONE_IN_5 && !PWM_SYNC_INPUT)
      else $error("peripheral input not idle after reset");
   a_pin34_gpio: assert property (!$past(SRST) |-> PAD_OE[5] == $past(GPIO_DIR[5]))
      else $error("last pin enable does not follow direction");
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus wait or error response");
   a_fsel_read: assert property (rp && HREADY && ad == OFS_A_FSEL_HIGH |-> HRDATA == {26'h0, fa})
      else $error("function select read differs from written value");
   a_mux_b_high: assert property (rp && HREADY && ad == OFS_B_FSEL_HIGH |-> HRDATA == 32'h0)
      else $error("reserved mux register reads nonzero");
   a_period_b_rsvd: assert property (rp && HREADY && ad == OFS_B_PERIOD |-> HRDATA[31:8] == 24'h0)
      else $error("reserved period bits read nonzero");
   a_qual_cause: assert property ($rose(GPIO_IN[0]) |-> $past(PAD_IN[0], 3) || $past(PAD_IN[0], 4)
      || $past(PAD_IN[0], 5))
      else $error("input rose without pad high");
   c_fsel_read: cover property (rp && ad == OFS_A_FSEL_HIGH);
   c_blocked_write: cover property (wp && !prot && ad == OFS_A_FSEL_HIGH);
   c_input_rise: cover property ($rose(GPIO_IN[0]));
endmodule : pinmux_checker

// ===== sim/periph_model.sv
// Partner: peripherals and general-purpose logic sharing the six pins
module periph_model
(
   // Pattern: bit 0 drive value, bit 1 output enable
   input wire logic [1:0] mode,
   // Drives toward the pin mux
   output logic [5:0] gpio_out,
   output logic [5:0] gpio_dir,
   output logic pv,
   output logic pe
);
   timeunit 1ns;
   timeprecision 1ns;
   // One shared value and enable keeps the expected pad table small
   assign gpio_out = {6{mode[0]}};
   assign gpio_dir = {6{mode[1]}};
   assign pv = mode[0];
   assign pe = mode[1];
endmodule : periph_model

// ===== sim/tb.sv
// Testbench: register access, pin function table and input qualification
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pinmux_pkg::*;
   logic clk = 1'b0, srst = 1'b1, hwrite = 1'b0, hreadyout, hresp, pv, pe;
   logic [1:0] htrans = 2'h0, mode = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic [5:0] pad_in = 6'h00, pad_out, pad_oe, gpio_in, gpio_out, gpio_dir, eo;
   wire [9:0] pin;
   logic [5:0] f1 [4] = '{6'h00, 6'h00, 6'h15, 6'h18};
   logic [5:0] fq [4] = '{6'h3f, 6'h3f, 6'h20, 6'h20};
   logic [5:0] vp [4] = '{6'h3f, 6'h27, 6'h35, 6'h38};
   logic [9:0] sel [4] = '{10'h000, 10'h386, 10'h041, 10'h038};
   int bad_count = 0, check_count = 0;
   always #5 clk = ~clk;
   periph_model partner (.mode(mode), .gpio_out(gpio_out), .gpio_dir(gpio_dir), .pv(pv), .pe(pe));
   pinmux_top dut
   (
      .CLK(clk), .SRST(srst), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe), .GPIO_OUT(gpio_out), .GPIO_DIR(gpio_dir),
      .GPIO_IN(gpio_in), .SPI_A_MOSI_OUT(pv), .SPI_A_MOSI_OE(pe), .SPI_A_MOSI_IN(pin[9]),
      .SPI_A_MISO_OUT(pv), .SPI_A_MISO_OE(pe), .SPI_A_MISO_IN(pin[8]), .SPI_A_SCLK_OUT(pv),
      .SPI_A_SCLK_OE(pe), .SPI_A_SCLK_IN(pin[7]), .CAN_B_TRANSMIT(pv), .CAN_B_RECEIVE(pin[6]),
      .UART_B_TRANSMIT(pv), .TRIP_ZONE_IN_1(pin[5]), .TRIP_ZONE_IN_5(pin[4]), .TRIP_ZONE_IN_6(pin[3]),
      .I2C_A_SDA_OE(pe), .I2C_A_SDA_IN(pin[2]), .I2C_A_SCL_OE(pe), .I2C_A_SCL_IN(pin[1]),
      .PWM_SYNC_INPUT(pin[0]), .PWM_SYNC_OUTPUT(pv), .ADC_CONVERSION_START_A_OUT(pv),
      .ADC_CONVERSION_START_B_OUT(pv)
   );
   // ****************************************
   // Checking, closing and bus tasks
   // ****************************************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task finish_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   // Both phases wait on ready under a bound, so a dead slave ends the run
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      for (int ph = 0; ph < 2; ph++)
      begin
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (hreadyout !== 1'b1 && n < 50);
         if (n >= 50)
         begin
            bad_count++;
            finish_test();
         end
         if (ph == 0)
         begin
            htrans <= 2'h0;
            hwdata <= d;
         end
      end
      q = hrdata;
   endtask : bus
   task wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      bus(1'b1, a, d);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : wrrd
   // ****************************************
   // Scenarios
   // ****************************************
   task t_regs;
      for (int a = 0; a <= 36; a += 4)
      begin
         bus(1'b0, 8'(a), 32'h0);
         chk(q, 32'h0);
      end
      wrrd(OFS_A_FSEL_HIGH, 32'h15, 32'h0);
      bus(1'b1, OFS_PROTECT, 32'h1);
      wrrd(OFS_A_FSEL_HIGH, 32'hffffffff, 32'h3f);
      wrrd(OFS_B_FSEL_LOW, 32'h0000000f, 32'hf);
      wrrd(OFS_B_FSEL_HIGH, 32'hffffffff, 32'h0);
      wrrd(OFS_B_PERIOD, 32'hffffffff, 32'hff);
      wrrd(OFS_A_PERIOD, 32'ha5c3e11f, 32'ha5c3e11f);
      bus(1'b1, OFS_PROTECT, 32'h0);
      wrrd(OFS_A_PERIOD, 32'h0, 32'ha5c3e11f);
      bus(1'b1, OFS_PROTECT, 32'h1);
      wrrd(OFS_A_PERIOD, 32'h00ff0000, 32'h00ff0000);
   endtask : t_regs
   task t_mux;
      for (int c = 0; c < 4; c++)
      begin
         // Pin 34 stays general purpose: its other codes are reserved
         bus(1'b1, OFS_A_FSEL_HIGH, {26'h0, 6'(c * 21)});
         bus(1'b1, OFS_B_FSEL_LOW, {28'h0, 4'(c * 5)});
         for (int m = 0; m < 4; m++)
         begin
            mode <= 2'(m);
            pad_in <= {6{m[0]}};
            repeat (8) @(posedge clk);
            eo = f1[c] | (fq[c] & {6{m[1]}});
            chk({26'h0, pad_oe}, {26'h0, eo});
            chk({26'h0, pad_out & eo}, {26'h0, vp[c] & eo & {6{m[0]}}});
            chk({22'h0, pin}, {22'h0, (10'h07e & ~sel[c]) | (sel[c] & {10{m[0]}})});
            chk({26'h0, gpio_in}, {26'h0, {6{m[0]}}});
         end
      end
   endtask : t_mux
   task t_qual;
      int p, s, n, seen;
      bus(1'b1, OFS_A_FSEL_HIGH, 32'h0);
      for (int k = 0; k < 4; k++)
      begin
         s = k[0] ? SAMPLES_SIX : SAMPLES_THREE;
         p = k[1] ? 6 : 1;
         bus(1'b1, OFS_A_QSEL_HIGH, {30'h0, k[0] ? QSEL_SIX : QSEL_THREE});
         bus(1'b1, OFS_A_PERIOD, k[1] ? 32'h00030000 : 32'h0);
         // Flush the window low first: the pad may still be high from the mux scenario
         pad_in <= 6'h00;
         repeat (s * p + 10) @(posedge clk);
         // A pulse one sample short of the window must be filtered out
         pad_in <= 6'h01;
         repeat ((s - 1) * p) @(posedge clk);
         pad_in <= 6'h00;
         seen = 0;
         repeat (s * p + 10)
         begin
            @(posedge clk);
            seen = seen | int'(gpio_in[0] !== 1'b0);
         end
         chk(32'(seen), 32'h0);
         pad_in <= 6'h01;
         n = 0;
         do
         begin
            @(posedge clk);
            n++;
         end
         while (gpio_in[0] !== 1'b1 && n < s * p + 10);
         chk({31'h0, gpio_in[0]}, 32'h1);
         chk(32'(n >= (s - 1) * p), 32'h1);
         if (gpio_in[0] !== 1'b1)
            finish_test();
         pad_in <= 6'h00;
         repeat (s * p + 10) @(posedge clk);
         chk({31'h0, gpio_in[0]}, 32'h0);
      end
   endtask : t_qual
   task t_reset;
      // Mid-run reset must drop live pad enables and stored mux fields
      chk({26'h0, pad_oe}, 32'h3f);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk({26'h0, pad_oe}, 32'h0);
      bus(1'b0, OFS_B_FSEL_LOW, 32'h0);
      chk(q, 32'h0);
   endtask : t_reset
   initial
   begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_mux();
      t_qual();
      t_reset();
      finish_test();
   end
endmodule : tb
bind pinmux_top pinmux_checker u_check
(
   .CLK, .SRST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
   .PAD_IN, .PAD_OE, .GPIO_DIR, .GPIO_IN, .CAN_B_RECEIVE, .TRIP_ZONE_IN_5, .PWM_SYNC_INPUT
);
